// [rtl/iam_defines.svh]
// Purpose: Constants for the two-wire slave address match block
// Assumes: Included by bare name from rtl files
// Notes:   Definitions only
`ifndef IAM_DEFINES_SVH
`define IAM_DEFINES_SVH

// ==========================================================
// Mode field codes
`define IAM_MODE_SLV7 4'h6
`define IAM_MODE_SLV10 4'h7
`define IAM_MODE_MASK_ACC 4'h9
`define IAM_MODE_SLV7_SS 4'he
`define IAM_MODE_SLV10_SS 4'hf

// ==========================================================
// Address layout and reset values
`define IAM_TEN_HDR 5'h1e
`define IAM_BYTE_BITS 4'h8
`define IAM_MASK_RST 8'hff
`define IAM_ADDR_RST 8'h00
`define IAM_BYTE_RST 8'h00

`endif

// [rtl/iam_pkg.sv]
// Purpose: Types shared by the address match block
// Assumes: Constants live in iam_defines.svh
// Notes:   Binary state codes written out
package iam_pkg;

    typedef enum logic [2:0] {
        IAM_S_IDLE  = 3'b000,
        IAM_S_SHIFT = 3'b001,
        IAM_S_ACK   = 3'b010,
        IAM_S_SKIP  = 3'b011
    } iam_state_t;

    typedef enum logic [1:0] {
        IAM_P_ADDR    = 2'b00,
        IAM_P_ADDR_LO = 2'b01,
        IAM_P_DATA    = 2'b10
    } iam_phase_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } iam_line_ev_t;

endpackage : iam_pkg

// [rtl/iam_line_watch.sv]
// Purpose: Edge and bus condition detector for clock and data lines
// Assumes: Line inputs already synchronous to i_mclk
// Notes:   One-cycle pulses, in the same cycle as the line change
`timescale 1ns/1ps
`default_nettype none
module iam_line_watch (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output var iam_pkg::iam_line_ev_t o_ev
);
    logic scl_q;
    logic sda_q;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= i_scl;
            sda_q <= i_sda;
        end
    end

    // Data moving while clock stays high is a start or stop
    always_comb begin
        o_ev.start = scl_q && i_scl && sda_q && !i_sda;
        o_ev.stop = scl_q && i_scl && !sda_q && i_sda;
        o_ev.rise = !scl_q && i_scl;
        o_ev.fall = scl_q && !i_scl;
    end
endmodule : iam_line_watch
`default_nettype wire

// [rtl/iam_masked_eq.sv]
// Purpose: Masked byte comparator
// Assumes: A set care bit demands equality
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module iam_masked_eq (
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic [7:0] i_care,
    output logic o_eq
);
    assign o_eq = ((i_a ^ i_b) & i_care) == 8'h00;
endmodule : iam_masked_eq
`default_nettype wire

// [rtl/iam_slave.sv]
// Purpose: Slave address recognition, acknowledge and buffer loading
// Assumes: One clock, bus lines synchronous to it, open-drain pads outside
// Notes:   Data transmit, stretch-on-receive and general call not handled
`timescale 1ns/1ps
`default_nettype none
`include "iam_defines.svh"

// Summary of operation
// R1 - After start, shift eight bits on rises
// R2 - Compare bits 7:1 at eighth fall
// R3 - Match and room: load, full, ack, flag
// R4 - Ack and load automatically for matched bytes
// R5 - Full or overflow: no ack, still flag
// R6 - Buffer read clears full; overflow firmware-cleared
// R7 - Flag on match; start/stop per mode
// R8 - Ten-bit header 11110 A9 A8 write
// R9 - High byte match sets reload, holds clock
// R10 - Low byte match sets reload again
// R11 - Repeated high byte read: no reload
// R12 - Configuration bit picks masking scheme
// R13 - Five-bit scheme: set bit is don't-care
// R14 - Ten-bit: mask bit one covers bits 1:0
// R15 - Top two ten-bit bits never masked
// R16 - Wide mask reached only in mode 1001
// R17 - Wide mask cleared bit don't-care, resets ones
// R18 - Wide mask 7:1 seven-bit, 7:0 ten-bit
// R19 - Firmware loads wide mask before slave mode
// R20 - Firmware reads buffer to learn address
// R21 - Port overrides data line when driving
// R22 - Mode codes select width and start/stop flags
// R23 - Hold data low whole ninth pulse
module iam_slave (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_port_enable_bit,
    input wire logic [3:0] i_port_mode_field,
    input wire logic i_mask_scheme_select,
    input wire logic [4:0] i_narrow_address_mask,
    input wire logic i_addr_wr,
    input wire logic [7:0] i_addr_wdata,
    input wire logic i_rbuf_rd,
    input wire logic i_ovf_clr,
    input wire logic i_irq_clr,
    output logic [7:0] o_receive_buffer,
    output logic o_buffer_full_flag,
    output logic o_receive_overflow_flag,
    output logic o_port_interrupt_flag,
    output logic o_high_byte_reload_flag,
    output logic o_rw_bit,
    output logic [7:0] o_addr_rdata,
    output logic [7:0] o_wide_address_mask,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_scl_out,
    output logic o_scl_oe
);
    // ==========================================================
    // Mode decode
    logic slave_on;
    logic ten_bit;
    logic ss_irq;
    logic mask_acc;

    // R22 mode decode
    assign slave_on = i_port_enable_bit && (i_port_mode_field == `IAM_MODE_SLV7
        || i_port_mode_field == `IAM_MODE_SLV10 || i_port_mode_field == `IAM_MODE_SLV7_SS
        || i_port_mode_field == `IAM_MODE_SLV10_SS);
    assign ten_bit = i_port_mode_field[0];
    assign ss_irq = i_port_mode_field[3];
    // R16 mask access mode
    assign mask_acc = i_mask_scheme_select && (i_port_mode_field == `IAM_MODE_MASK_ACC);

    // ==========================================================
    // Line events
    iam_pkg::iam_line_ev_t ev;

    iam_line_watch u_watch (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_ev(ev)
    );

    // ==========================================================
    // Address and mask registers
    logic [7:0] own_address_register;

    // R16 writes steered by mode
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            own_address_register <= `IAM_ADDR_RST;
        end else if (i_addr_wr && !mask_acc) begin
            own_address_register <= i_addr_wdata;
        end
    end

    // R17 mask resets to ones
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_wide_address_mask <= `IAM_MASK_RST;
        end else if (i_addr_wr && mask_acc) begin
            o_wide_address_mask <= i_addr_wdata;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_addr_rdata <= `IAM_ADDR_RST;
        end else begin
            o_addr_rdata <= mask_acc ? o_wide_address_mask : own_address_register;
        end
    end

    // ==========================================================
    // Shifter and sequencing state
    iam_pkg::iam_state_t state;
    iam_pkg::iam_phase_t phase;
    logic [7:0] serial_shift_register;
    logic [3:0] bit_cnt;
    logic matched10;
    logic irq_pend;
    logic rx_after;

    // ==========================================================
    // Match computation
    logic [7:0] care;
    logic masked_hit;
    logic hdr_hit;
    logic byte_done;
    logic hit;
    logic room;

    // R12 scheme select, R13 R14 R15 R17 R18 care bits
    always_comb begin
        care = 8'h00;
        if (phase == iam_pkg::IAM_P_ADDR_LO) begin
            if (i_mask_scheme_select) begin
                care = o_wide_address_mask;
            end else begin
                care = {2'b11, ~i_narrow_address_mask[4:1], {2{~i_narrow_address_mask[0]}}};
            end
        end else begin
            if (i_mask_scheme_select) begin
                care = {o_wide_address_mask[7:1], 1'b0};
            end else begin
                care = {2'b11, ~i_narrow_address_mask, 1'b0};
            end
        end
    end

    iam_masked_eq u_cmp (
        .i_a(serial_shift_register),
        .i_b(own_address_register),
        .i_care(care),
        .o_eq(masked_hit)
    );

    // R8 R15 header compared unmasked
    assign hdr_hit = serial_shift_register[7:3] == `IAM_TEN_HDR
        && serial_shift_register[2:1] == own_address_register[2:1];

    // R2 compare at eighth fall
    assign byte_done = state == iam_pkg::IAM_S_SHIFT && ev.fall && bit_cnt == `IAM_BYTE_BITS;

    always_comb begin
        hit = 1'b0;
        unique case (phase)
            iam_pkg::IAM_P_ADDR: begin
                if (ten_bit) begin
                    hit = hdr_hit && (!serial_shift_register[0] || matched10);
                end else begin
                    hit = masked_hit;
                end
            end
            iam_pkg::IAM_P_ADDR_LO: hit = masked_hit;
            iam_pkg::IAM_P_DATA: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    assign room = !o_buffer_full_flag && !o_receive_overflow_flag;

    // ==========================================================
    // Sequencer
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state <= iam_pkg::IAM_S_IDLE;
            phase <= iam_pkg::IAM_P_ADDR;
            bit_cnt <= 4'h0;
            matched10 <= 1'b0;
            rx_after <= 1'b0;
        end else if (!slave_on || ev.stop) begin
            state <= iam_pkg::IAM_S_IDLE;
            phase <= iam_pkg::IAM_P_ADDR;
            bit_cnt <= 4'h0;
            matched10 <= 1'b0;
            rx_after <= 1'b0;
        end else if (ev.start) begin
            // R1 start arms the shifter
            state <= iam_pkg::IAM_S_SHIFT;
            phase <= iam_pkg::IAM_P_ADDR;
            bit_cnt <= 4'h0;
        end else begin
            unique case (state)
                iam_pkg::IAM_S_IDLE: begin
                    bit_cnt <= 4'h0;
                end
                iam_pkg::IAM_S_SHIFT: begin
                    if (ev.rise && bit_cnt != `IAM_BYTE_BITS) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (byte_done) begin
                        state <= hit ? iam_pkg::IAM_S_ACK : iam_pkg::IAM_S_SKIP;
                        rx_after <= 1'b0;
                        if (phase == iam_pkg::IAM_P_ADDR && ten_bit && !serial_shift_register[0]) begin
                            phase <= iam_pkg::IAM_P_ADDR_LO;
                            rx_after <= 1'b1;
                        end else if (phase == iam_pkg::IAM_P_ADDR_LO) begin
                            phase <= iam_pkg::IAM_P_DATA;
                            matched10 <= hit;
                            rx_after <= 1'b1;
                        end else if (phase == iam_pkg::IAM_P_ADDR && !ten_bit) begin
                            phase <= iam_pkg::IAM_P_DATA;
                            rx_after <= !serial_shift_register[0];
                        end else if (phase == iam_pkg::IAM_P_DATA) begin
                            rx_after <= 1'b1;
                        end
                    end
                end
                iam_pkg::IAM_S_ACK: begin
                    if (ev.fall) begin
                        state <= rx_after ? iam_pkg::IAM_S_SHIFT : iam_pkg::IAM_S_SKIP;
                        bit_cnt <= 4'h0;
                    end
                end
                iam_pkg::IAM_S_SKIP: begin
                    bit_cnt <= 4'h0;
                end
                default: state <= iam_pkg::IAM_S_IDLE;
            endcase
        end
    end

    // R1 sample data on clock rise
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            serial_shift_register <= `IAM_BYTE_RST;
        end else if (state == iam_pkg::IAM_S_SHIFT && ev.rise && bit_cnt != `IAM_BYTE_BITS) begin
            serial_shift_register <= {serial_shift_register[6:0], i_sda};
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_rw_bit <= 1'b0;
        end else if (byte_done && hit && phase == iam_pkg::IAM_P_ADDR) begin
            o_rw_bit <= serial_shift_register[0];
        end
    end

    // ==========================================================
    // Buffer and status flags
    logic load;

    // R3 R4 load only with room
    assign load = byte_done && hit && room;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_receive_buffer <= `IAM_BYTE_RST;
        end else if (load) begin
            o_receive_buffer <= serial_shift_register;
        end
    end

    // R6 read clears full, set wins
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_buffer_full_flag <= 1'b0;
        end else if (load) begin
            o_buffer_full_flag <= 1'b1;
        end else if (i_rbuf_rd) begin
            o_buffer_full_flag <= 1'b0;
        end
    end

    // R5 R6 overflow kept until firmware
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_receive_overflow_flag <= 1'b0;
        end else if (byte_done && hit && o_buffer_full_flag) begin
            o_receive_overflow_flag <= 1'b1;
        end else if (i_ovf_clr) begin
            o_receive_overflow_flag <= 1'b0;
        end
    end

    // R5 R7 flag owed even without ack
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            irq_pend <= 1'b0;
        end else if (byte_done) begin
            irq_pend <= hit;
        end else if (state == iam_pkg::IAM_S_ACK && ev.fall) begin
            irq_pend <= 1'b0;
        end
    end

    // R3 R7 flag at ninth fall or start/stop
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_port_interrupt_flag <= 1'b0;
        end else if ((state == iam_pkg::IAM_S_ACK && ev.fall && irq_pend)
                || (slave_on && ss_irq && (ev.start || ev.stop))) begin
            o_port_interrupt_flag <= 1'b1;
        end else if (i_irq_clr) begin
            o_port_interrupt_flag <= 1'b0;
        end
    end

    // ==========================================================
    // Reload flag and clock hold
    logic ua_set;

    // R9 R10 R11 reload on write address bytes only
    assign ua_set = byte_done && hit && ten_bit
        && (phase == iam_pkg::IAM_P_ADDR_LO || (phase == iam_pkg::IAM_P_ADDR && !serial_shift_register[0]));

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_high_byte_reload_flag <= 1'b0;
        end else if (ua_set) begin
            o_high_byte_reload_flag <= 1'b1;
        end else if ((i_addr_wr && !mask_acc) || !slave_on) begin
            o_high_byte_reload_flag <= 1'b0;
        end
    end

    // Hold only once clock is low, so the master's high time is never cut
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_scl_oe <= 1'b0;
            o_scl_out <= 1'b0;
        end else if (!o_high_byte_reload_flag || !slave_on) begin
            o_scl_oe <= 1'b0;
        end else if (!i_scl && state != iam_pkg::IAM_S_ACK) begin
            o_scl_oe <= 1'b1;
        end
    end

    // ==========================================================
    // Acknowledge drive
    // R21 R23 drive low through ninth pulse
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_sda_oe <= 1'b0;
            o_sda_out <= 1'b0;
        end else if (!slave_on || ev.start || ev.stop) begin
            o_sda_oe <= 1'b0;
        end else if (load) begin
            o_sda_oe <= 1'b1;
        end else if (state == iam_pkg::IAM_S_ACK && ev.fall) begin
            o_sda_oe <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    ack_count_a: assert property (state == iam_pkg::IAM_S_ACK |-> bit_cnt == 4'h8) // R1
        else $error("ack entered before eight bits");
    compare_edge_a: assert property ($rose(o_sda_oe) |-> $past(ev.fall) && $past(bit_cnt) == 4'h8) // R2
        else $error("ack began away from eighth fall");
    match_load_a: assert property (byte_done && hit && room |=> // R3
        o_buffer_full_flag && o_sda_oe && o_receive_buffer == $past(serial_shift_register))
        else $error("match with room did not load and ack");
    full_noack_a: assert property (byte_done && hit && !room |=> // R5
        !o_sda_oe && $stable(o_receive_buffer) ##0 irq_pend)
        else $error("full buffer was acked or changed");
    read_clear_a: assert property (i_rbuf_rd && !load |=> !o_buffer_full_flag) // R6
        else $error("buffer read left full set");
    ovf_sticky_a: assert property (o_receive_overflow_flag && !i_ovf_clr |=> o_receive_overflow_flag) // R6
        else $error("overflow dropped without firmware");
    ninth_irq_a: assert property (state == iam_pkg::IAM_S_ACK && ev.fall && irq_pend |=> o_port_interrupt_flag) // R7
        else $error("flag missing at ninth fall");
    reload_rel_a: assert property (i_addr_wr && !mask_acc && !ua_set && o_high_byte_reload_flag // R9
        |=> !o_high_byte_reload_flag ##1 !o_scl_oe)
        else $error("address write did not release clock");
    mask_guard_a: assert property (i_addr_wr && !mask_acc |=> $stable(o_wide_address_mask)) // R16
        else $error("mask written outside access mode");
    ack_window_a: assert property (o_sda_oe |-> state == iam_pkg::IAM_S_ACK) // R23
        else $error("data line driven outside ack pulse");
endmodule : iam_slave
`default_nettype wire

// [dv/iam_bus_model.sv]
// Purpose: Two-wire bus master model for the address match block
// Assumes: Both lines pulled up, this model only pulls low
// Notes:   HALF mclk cycles per clock phase; stretch wait is bounded
`timescale 1ns/1ps
`default_nettype none
module iam_bus_model #(
    parameter int HALF = 8
) (
    input wire logic i_mclk,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl_low,
    output logic o_sda_low
);
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : tick
    // Slave may stretch; give up after a bound so a hang shows
    task automatic rise();
        int n;
        n = 0;
        o_scl_low <= 1'b0;
        tick(1);
        while (i_scl !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        tick(HALF);
    endtask : rise
    // Works from idle and as repeated start with clock low
    task automatic start();
        tick(1);
        o_sda_low <= 1'b0;
        tick(HALF);
        rise();
        o_sda_low <= 1'b1;
        tick(HALF);
        o_scl_low <= 1'b1;
        tick(HALF);
    endtask : start
    task automatic stop();
        o_sda_low <= 1'b1;
        tick(HALF);
        rise();
        o_sda_low <= 1'b0;
        tick(HALF);
    endtask : stop
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            o_sda_low <= ~b[i];
            tick(HALF);
            rise();
            o_scl_low <= 1'b1;
        end
        o_sda_low <= 1'b0;
        tick(HALF);
        rise();
        ack = (i_sda === 1'b0);
        tick(HALF - 2);
        ack = ack && (i_sda === 1'b0);
        o_scl_low <= 1'b1;
        tick(4);
    endtask : send
endmodule : iam_bus_model
`default_nettype wire

// [dv/iam_slave_bench.sv]
// Purpose: Self-checking bench for the slave address match block
// Assumes: Bus model as master, firmware actions as port pulses
// Notes:   Scenarios run in sequence, one task each
`timescale 1ns/1ps
`default_nettype none
module iam_slave_bench;
    logic clk, rst, en, msel, awr, rrd, oclr, iclr;
    logic [3:0] mode;
    logic [4:0] nmask;
    logic [7:0] awd, rbuf, ardata, wmask;
    logic full, ovf, irq, rel, rw, sda_o, sda_oe, scl_o, scl_oe;
    logic m_scl_low, m_sda_low;
    wire logic scl, sda;
    int err_count = 0;
    int checks = 0;
    assign scl = ~(m_scl_low | (scl_oe & ~scl_o));
    assign sda = ~(m_sda_low | (sda_oe & ~sda_o));
    iam_slave u_iam_slave (.i_mclk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
        .i_port_enable_bit(en), .i_port_mode_field(mode), .i_mask_scheme_select(msel),
        .i_narrow_address_mask(nmask), .i_addr_wr(awr), .i_addr_wdata(awd),
        .i_rbuf_rd(rrd), .i_ovf_clr(oclr), .i_irq_clr(iclr), .o_receive_buffer(rbuf),
        .o_buffer_full_flag(full), .o_receive_overflow_flag(ovf),
        .o_port_interrupt_flag(irq), .o_high_byte_reload_flag(rel), .o_rw_bit(rw),
        .o_addr_rdata(ardata), .o_wide_address_mask(wmask), .o_sda_out(sda_o),
        .o_sda_oe(sda_oe), .o_scl_out(scl_o), .o_scl_oe(scl_oe));
    iam_bus_model u_iam_bus_model (.i_mclk(clk), .i_scl(scl), .i_sda(sda),
        .o_scl_low(m_scl_low), .o_sda_low(m_sda_low));
    // ==========================================================
    // Helpers
    task automatic chk_b(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_b
    task automatic chk_f(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_f
    // Firmware pulses, one cycle each, then a settle cycle
    task automatic fw(input logic w, input logic [7:0] v, input logic r, input logic q);
        @(posedge clk);
        awr <= w;
        awd <= v;
        rrd <= r;
        iclr <= q;
        oclr <= 1'b0;
        @(posedge clk);
        {awr, rrd, iclr} <= 3'b000;
        @(posedge clk);
    endtask : fw
    task automatic xfer(input logic [7:0] b, input logic e);
        logic a;
        u_iam_bus_model.send(b, a);
        chk_f("ack", e, a);
    endtask : xfer
    task automatic wrap_up();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk_b("mask", 8'hff, wmask);
        chk_b("flags", 8'h00, {4'h0, full, ovf, irq, rel});
        chk_b("rbuf", 8'h00, rbuf);
        chk_f("sda_out", 1'b0, sda_o);
        chk_f("scl_out", 1'b0, scl_o);
        chk_f("sda_oe", 1'b0, sda_oe);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_seven();
        mode <= 4'h6;
        fw(1'b1, 8'ha0, 1'b0, 1'b1);
        u_iam_bus_model.start();
        xfer(8'ha0, 1'b1);
        chk_b("rbuf", 8'ha0, rbuf);
        chk_f("full", 1'b1, full);
        chk_f("irq", 1'b1, irq);
        chk_f("rw", 1'b0, rw);
        chk_f("sda_oe", 1'b0, sda_oe);
        fw(1'b0, 8'h00, 1'b0, 1'b1);
        xfer(8'h55, 1'b0);
        chk_b("rbuf", 8'ha0, rbuf);
        chk_f("irq", 1'b1, irq);
        chk_f("ovf", 1'b1, ovf);
        u_iam_bus_model.stop();
        fw(1'b0, 8'h00, 1'b1, 1'b1);
        chk_f("full", 1'b0, full);
        chk_f("ovf", 1'b1, ovf);
        oclr <= 1'b1;
        @(posedge clk);
        oclr <= 1'b0;
        @(posedge clk);
        chk_f("ovf", 1'b0, ovf);
        u_iam_bus_model.start();
        xfer(8'h52, 1'b0);
        u_iam_bus_model.stop();
        chk_f("irq", 1'b0, irq);
        $display("t_seven done");
    endtask : t_seven
    task automatic t_wide();
        mode <= 4'h9;
        fw(1'b1, 8'hf3, 1'b0, 1'b0);
        chk_b("mask", 8'hf3, wmask);
        mode <= 4'h6;
        fw(1'b0, 8'h00, 1'b0, 1'b0);
        chk_b("own", 8'ha0, ardata);
        u_iam_bus_model.start();
        xfer(8'hac, 1'b1);
        u_iam_bus_model.stop();
        fw(1'b0, 8'h00, 1'b1, 1'b1);
        u_iam_bus_model.start();
        xfer(8'ha2, 1'b0);
        u_iam_bus_model.stop();
        $display("t_wide done");
    endtask : t_wide
    task automatic t_narrow();
        msel <= 1'b0;
        nmask <= 5'h07;
        u_iam_bus_model.start();
        xfer(8'hae, 1'b1);
        u_iam_bus_model.stop();
        fw(1'b0, 8'h00, 1'b1, 1'b1);
        u_iam_bus_model.start();
        xfer(8'hb0, 1'b0);
        u_iam_bus_model.stop();
        msel <= 1'b1;
        u_iam_bus_model.start();
        xfer(8'hae, 1'b0);
        u_iam_bus_model.stop();
        $display("t_narrow done");
    endtask : t_narrow
    task automatic t_ten();
        msel <= 1'b0;
        nmask <= 5'h1f;
        mode <= 4'h7;
        fw(1'b1, 8'hf2, 1'b0, 1'b1);
        u_iam_bus_model.start();
        xfer(8'hf4, 1'b0);
        u_iam_bus_model.stop();
        nmask <= 5'h01;
        u_iam_bus_model.start();
        xfer(8'hf2, 1'b1);
        chk_f("reload", 1'b1, rel);
        chk_f("full", 1'b1, full);
        chk_f("hold", 1'b1, scl_oe);
        fw(1'b1, 8'h50, 1'b1, 1'b1);
        fw(1'b0, 8'h00, 1'b0, 1'b0);
        chk_f("reload", 1'b0, rel);
        chk_f("hold", 1'b0, scl_oe);
        xfer(8'h53, 1'b1);
        chk_f("reload", 1'b1, rel);
        chk_f("irq", 1'b1, irq);
        fw(1'b1, 8'hf2, 1'b1, 1'b1);
        u_iam_bus_model.start();
        xfer(8'hf3, 1'b1);
        chk_f("reload", 1'b0, rel);
        chk_f("full", 1'b1, full);
        chk_f("rw", 1'b1, rw);
        u_iam_bus_model.stop();
        fw(1'b0, 8'h00, 1'b1, 1'b1);
        $display("t_ten done");
    endtask : t_ten
    task automatic t_modes();
        logic [3:0] codes [4] = '{4'h6, 4'h7, 4'he, 4'hf};
        msel <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            mode <= codes[i];
            fw(1'b0, 8'h00, 1'b0, 1'b1);
            u_iam_bus_model.start();
            u_iam_bus_model.stop();
            chk_f("irq", codes[i][3], irq);
        end
        $display("t_modes done");
    endtask : t_modes
    // ==========================================================
    // Clock, reset, sequence, watchdog
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        {en, awr, rrd, oclr, iclr} = 5'h00;
        msel = 1'b1;
        mode = 4'h0;
        nmask = 5'h00;
        awd = 8'h00;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        en <= 1'b1;
        @(posedge clk);
        t_reset();
        t_seven();
        t_wide();
        t_narrow();
        t_ten();
        t_modes();
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        $display("Error watchdog expected done seen hang");
        wrap_up();
    end
endmodule : iam_slave_bench
`default_nettype wire
